// [rtccm_pkg.sv]
`default_nettype none
package rtccm_pkg;
   // ------------------------------------------------------------
   // host port addresses
   // ------------------------------------------------------------
   localparam logic [7:0] PORT_INDEX = 8'h70;
   localparam logic [7:0] PORT_DATA = 8'h71;
   localparam int NVRAM_BYTES = 128;
   // ------------------------------------------------------------
   // location map
   // ------------------------------------------------------------
   localparam logic [6:0] LOC_TIME_SEC = 7'h00;
   localparam logic [6:0] LOC_ALARM_SEC = 7'h01;
   localparam logic [6:0] LOC_TIME_MIN = 7'h02;
   localparam logic [6:0] LOC_ALARM_MIN = 7'h03;
   localparam logic [6:0] LOC_TIME_HOUR = 7'h04;
   localparam logic [6:0] LOC_ALARM_HOUR = 7'h05;
   localparam logic [6:0] LOC_WEEKDAY = 7'h06;
   localparam logic [6:0] LOC_MONTH_DAY = 7'h07;
   localparam logic [6:0] LOC_MONTH = 7'h08;
   localparam logic [6:0] LOC_YEAR = 7'h09;
   localparam logic [6:0] LOC_RATE_CTRL = 7'h0a;
   localparam logic [6:0] LOC_MODE_CTRL = 7'h0b;
   localparam logic [6:0] LOC_EVENT_FLAGS = 7'h0c;
   localparam logic [6:0] LOC_POWER_VALID = 7'h0d;
   localparam logic [6:0] LOC_PWR_CSUM = 7'h0e;
   localparam logic [6:0] LOC_CSUM_HIGH = 7'h2e;
   localparam logic [6:0] LOC_CSUM_LOW = 7'h2f;
   localparam logic [6:0] LOC_CENTURY = 7'h32;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_UIP = 7;
   localparam int BIT_HALT = 7;
   localparam int BIT_PIE = 6;
   localparam int BIT_AIE = 5;
   localparam int BIT_UIE = 4;
   localparam int BIT_SQWE = 3;
   localparam int BIT_BINARY = 2;
   localparam int BIT_H24 = 1;
   localparam int BIT_DSE = 0;
   localparam int BIT_IRQF = 7;
   localparam int BIT_VRT = 7;
   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [6:0] RATE_CTRL_RST = 7'h26;
   localparam logic [7:0] MODE_CTRL_RST = 8'h02;
   localparam int CLK_HZ = 100_000_000;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int UIP_CYCLES = 244;
   // host bus access, one cycle strobes
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtccm_req_t;
endpackage : rtccm_pkg
`default_nettype wire

// [rtccm_core.sv]
`default_nettype none
// Functional notes
// - index port selects location, data port moves the byte
// - 128 bytes of storage at 00h-7Fh kept while main power off
// - time and date at 00h,02h,04h,06h,07h,08h,09h
// - alarm seconds, minutes, hours at 01h,03h,05h, same format
// - status A bit 7 reads one during update, read only
// - status A bits 6-4 divider, bits 3-0 periodic and square rate
// - status B bit 6 enables periodic interrupt
// - status B bit 5 enables alarm interrupt
// - status B bit 4 enables update-ended interrupt
// - status B bit 3 enables square-wave output
// - status B bit 2 selects BCD (0) or binary (1)
// - status B bit 1 selects 12-hour (0) or 24-hour (1); hours here always count 00-23, bit 1 is unused
// - status B bit 0 enables daylight-saving adjustment; no adjustment is made here, bit 0 is unused
// - status C bits 6,5,4 report periodic, alarm, update events
// - status C bit 7 set when an enabled event flag is set
// - interrupt goes out on request line 8
// - status D bit 7 reads one when power stayed valid
module rtccm_core #(
   parameter int SEC_CYCLES = rtccm_pkg::SEC_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire rtccm_pkg::rtccm_req_t req_i,
   input wire logic power_valid_i,
   output logic [7:0] rdata_o,
   output logic irq8_o,
   output logic sqw_o
);
   // ------------------------------------------------------------
   // storage and index
   // ------------------------------------------------------------
   // plain array: battery backed, so contents are not cleared
   logic [7:0] mem_q [rtccm_pkg::NVRAM_BYTES];
   logic [6:0] index_q;
   logic [6:0] rate_q;
   logic [7:0] mode_q;
   logic [2:0] flags_q;
   logic [7:0] rdata_q;
   logic [31:0] sec_cnt_q;
   logic [15:0] uip_cnt_q;
   logic [15:0] per_cnt_q;
   logic sqw_q;
   logic [7:0] sec_q, min_q, hour_q;

   wire idx_wr = req_i.wr && req_i.addr == rtccm_pkg::PORT_INDEX;
   wire dat_wr = req_i.wr && req_i.addr == rtccm_pkg::PORT_DATA;
   wire dat_rd = req_i.rd && req_i.addr == rtccm_pkg::PORT_DATA;
   wire halt = mode_q[rtccm_pkg::BIT_HALT];
   wire binary = mode_q[rtccm_pkg::BIT_BINARY];
   wire sec_tick = !halt && sec_cnt_q == 32'(SEC_CYCLES - 1);
   wire uip = uip_cnt_q != 16'h0000;
   wire upd_done = uip_cnt_q == 16'h0001;
   wire flags_rd = dat_rd && index_q == rtccm_pkg::LOC_EVENT_FLAGS;
   wire [2:0] flag_en = mode_q[6:4];
   wire irq_pend = |(flags_q & flag_en);

   // ------------------------------------------------------------
   // time counting, bcd or binary
   // ------------------------------------------------------------
   function automatic logic [7:0] inc_wrap(input logic [7:0] v,
      input logic [7:0] lim, input logic bin);
      logic [7:0] r;
      r = 8'h00;
      if (bin)
      begin
         r = (v >= lim) ? 8'h00 : v + 8'h01;
      end
      else if (v >= lim)
      begin
         r = 8'h00;
      end
      else if (v[3:0] >= 4'h9)
      begin
         r = {v[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         r = v + 8'h01;
      end
      return r;
   endfunction : inc_wrap

   wire [7:0] lim59 = binary ? 8'h3b : 8'h59;
   wire [7:0] lim23 = binary ? 8'h17 : 8'h23;
   wire [7:0] sec_n = inc_wrap(sec_q, lim59, binary);
   wire [7:0] min_n = inc_wrap(min_q, lim59, binary);
   wire [7:0] hour_n = inc_wrap(hour_q, lim23, binary);
   wire min_wrap = sec_q >= lim59;
   wire hour_wrap = min_wrap && min_q >= lim59;
   // alarm compares the values about to land, so the flag rises
   // in the same update that reaches the alarm time
   wire [7:0] min_nx = min_wrap ? min_n : min_q;
   wire [7:0] hour_nx = hour_wrap ? hour_n : hour_q;
   wire alarm_hit = sec_n == mem_q[rtccm_pkg::LOC_ALARM_SEC] &&
      min_nx == mem_q[rtccm_pkg::LOC_ALARM_MIN] &&
      hour_nx == mem_q[rtccm_pkg::LOC_ALARM_HOUR];

   // one second base; halt clears it and holds it at zero
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sec_cnt_q <= 32'h0000_0000;
      else if (halt || sec_tick)
         sec_cnt_q <= 32'h0000_0000;
      else
         sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
   end

   // update window, flag visible until the counters advance at its end
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         uip_cnt_q <= 16'h0000;
      else if (sec_tick)
         uip_cnt_q <= 16'(rtccm_pkg::UIP_CYCLES);
      else if (uip)
         uip_cnt_q <= uip_cnt_q - 16'h0001;
   end

   // ------------------------------------------------------------
   // time registers kept apart for counting
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sec_q <= 8'h00;
         min_q <= 8'h00;
         hour_q <= 8'h00;
      end
      else if (dat_wr && index_q == rtccm_pkg::LOC_TIME_SEC)
         sec_q <= req_i.wdata;
      else if (dat_wr && index_q == rtccm_pkg::LOC_TIME_MIN)
         min_q <= req_i.wdata;
      else if (dat_wr && index_q == rtccm_pkg::LOC_TIME_HOUR)
         hour_q <= req_i.wdata;
      else if (upd_done && !halt)
      begin
         sec_q <= sec_n;
         if (min_wrap)
            min_q <= min_n;
         if (hour_wrap)
            hour_q <= hour_n;
      end
   end

   // ------------------------------------------------------------
   // general storage, no reset on purpose
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (dat_wr)
         mem_q[index_q] <= req_i.wdata;
   end

   // ------------------------------------------------------------
   // index and control registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         index_q <= 7'h00;
      else if (idx_wr)
         index_q <= req_i.wdata[6:0];
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rate_q <= rtccm_pkg::RATE_CTRL_RST;
         mode_q <= rtccm_pkg::MODE_CTRL_RST;
      end
      else if (dat_wr && index_q == rtccm_pkg::LOC_RATE_CTRL)
         rate_q <= req_i.wdata[6:0];
      else if (dat_wr && index_q == rtccm_pkg::LOC_MODE_CTRL)
         mode_q <= req_i.wdata;
   end

   // ------------------------------------------------------------
   // periodic and square-wave rate
   // ------------------------------------------------------------
   // rate code n gives a period of 2^(n-1) base steps; 0 stops it
   wire [3:0] rs = rate_q[3:0];
   wire per_on = rs != 4'h0 && rate_q[6:4] == 3'b010;
   wire [15:0] per_lim = 16'h0001 << (rs - 4'h1);
   wire per_tick = per_on && per_cnt_q >= per_lim - 16'h0001;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         per_cnt_q <= 16'h0000;
         sqw_q <= 1'b0;
      end
      else if (!per_on)
      begin
         per_cnt_q <= 16'h0000;
         sqw_q <= 1'b0;
      end
      else if (per_tick)
      begin
         per_cnt_q <= 16'h0000;
         sqw_q <= ~sqw_q;
      end
      else
         per_cnt_q <= per_cnt_q + 16'h0001;
   end

   // ------------------------------------------------------------
   // event flags; a new event beats a clearing read
   // ------------------------------------------------------------
   wire [2:0] ev = {per_tick, upd_done && alarm_hit, upd_done};
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flags_q <= 3'b000;
      else
         flags_q <= (flags_rd ? 3'b000 : flags_q) | ev;
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb
   begin
      case (index_q)
         rtccm_pkg::LOC_TIME_SEC: rd_mux = sec_q;
         rtccm_pkg::LOC_TIME_MIN: rd_mux = min_q;
         rtccm_pkg::LOC_TIME_HOUR: rd_mux = hour_q;
         rtccm_pkg::LOC_RATE_CTRL: rd_mux = {uip, rate_q};
         rtccm_pkg::LOC_MODE_CTRL: rd_mux = mode_q;
         rtccm_pkg::LOC_EVENT_FLAGS:
            rd_mux = {irq_pend, flags_q, 4'h0};
         rtccm_pkg::LOC_POWER_VALID:
            rd_mux = {power_valid_i, 7'h00};
         default: rd_mux = mem_q[index_q];
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_q <= 8'h00;
      else if (dat_rd)
         rdata_q <= rd_mux;
   end

   assign rdata_o = rdata_q;
   assign irq8_o = irq_pend;
   assign sqw_o = sqw_q && mode_q[rtccm_pkg::BIT_SQWE];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence rd_flags_s;
      flags_rd && ev == 3'b000;
   endsequence

   flags_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_flags_s |=> flags_q == 3'b000 && !irq8_o)
      else $error("flags not cleared by read");
   irq_cause_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      irq8_o |-> |(flags_q & mode_q[6:4]))
      else $error("irq without enabled flag");
   halt_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      halt && !dat_wr |=> $stable(sec_q))
      else $error("time moved while halted");
   uip_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sec_tick |=> uip [*8])
      else $error("update flag too short");
   upd_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      upd_done |=> flags_q[0])
      else $error("update flag not set");
   idx_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      idx_wr |=> index_q == $past(req_i.wdata[6:0]))
      else $error("index not loaded");
   sqw_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !mode_q[rtccm_pkg::BIT_SQWE] |-> !sqw_o)
      else $error("square wave while disabled");
   pwr_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      dat_rd && index_q == rtccm_pkg::LOC_POWER_VALID
      |=> rdata_o[7] == $past(power_valid_i))
      else $error("power valid bit wrong");
endmodule : rtccm_core
`default_nettype wire

// [rtccm_host.sv]
`default_nettype none
// ------------------------------------------------------------
// host processor model: index port and data port cycles
// ------------------------------------------------------------
module rtccm_host (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output var rtccm_pkg::rtccm_req_t req_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // strobes idle low from time zero
   initial req_o = '0;

   // one strobe cycle, set 1 ns after an edge, dropped after the next
   task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk_i);
      #1;
      req_o = '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk_i);
      #1;
      req_o = '0;
   endtask : cyc

   // the index is always loaded before the data port is touched
   task automatic put(input logic [6:0] loc, input logic [7:0] d);
      cyc(1'b1, 1'b0, rtccm_pkg::PORT_INDEX, {1'b0, loc});
      cyc(1'b1, 1'b0, rtccm_pkg::PORT_DATA, d);
   endtask : put

   // read data stands until the next data read, so a late look is safe
   task automatic get(input logic [6:0] loc, output logic [7:0] d);
      cyc(1'b1, 1'b0, rtccm_pkg::PORT_INDEX, {1'b0, loc});
      cyc(1'b0, 1'b1, rtccm_pkg::PORT_DATA, 8'h00);
      @(posedge clk_i);
      #1;
      d = rdata_i;
   endtask : get
endmodule : rtccm_host
`default_nettype wire

// [test_rtc_cmos_register_map.sv]
`default_nettype none
module test_rtc_cmos_register_map;
   timeunit 1ns;
   timeprecision 100ps;
   // short second keeps the run small; update window stays 244 cycles
   localparam int SEC = 300;
   logic mclk_i;
   logic rst_n_i;
   logic power_valid_i;
   rtccm_pkg::rtccm_req_t req;
   logic [7:0] rdata;
   logic irq8;
   logic sqw;
   logic [7:0] rd;
   logic [6:0] locs [6] = '{7'h0e, 7'h10, 7'h2e, 7'h2f, 7'h32, 7'h7f};
   logic [7:0] vals [6] = '{8'hc0, 8'ha5, 8'h12, 8'h34, 8'h20, 8'h5a};
   int n_fail;
   int checks;
   int flips;

   rtccm_core #(.SEC_CYCLES(SEC)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .req_i(req), .power_valid_i(power_valid_i), .rdata_o(rdata),
      .irq8_o(irq8), .sqw_o(sqw));
   rtccm_host host (.clk_i(mclk_i), .rdata_i(rdata), .req_o(req));

   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // read one location and compare the bits under the mask
   task automatic look(input logic [6:0] loc, input logic [7:0] m,
                       input logic [7:0] exp);
      host.get(loc, rd);
      chk(rd & m, exp);
   endtask : look

   // counts square-wave edges over a fixed span
   task automatic count_sqw(input int n);
      logic last;
      flips = 0;
      last = sqw;
      repeat (n)
      begin
         @(posedge mclk_i);
         #1;
         if (sqw !== last)
            flips++;
         last = sqw;
      end
   endtask : count_sqw

   task automatic close_out();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // clock, watchdog and test sequence
   // ------------------------------------------------------------
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // the whole sequence needs about 1100 cycles
   initial
   begin
      #200000;
      n_fail++;
      close_out();
   end

   initial
   begin
      n_fail = 0;
      checks = 0;
      power_valid_i = 1'b1;
      rst_n_i = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1;
      rst_n_i = 1'b1;
      look(rtccm_pkg::LOC_RATE_CTRL, 8'h7f, 8'h26);
      look(rtccm_pkg::LOC_MODE_CTRL, 8'hff, 8'h02);
      look(rtccm_pkg::LOC_POWER_VALID, 8'h80, 8'h80);
      power_valid_i = 1'b0;
      look(rtccm_pkg::LOC_POWER_VALID, 8'h80, 8'h00);
      power_valid_i = 1'b1;
      // halted, so no update window can make bit 7 read high
      host.put(rtccm_pkg::LOC_MODE_CTRL, 8'h82);
      host.put(rtccm_pkg::LOC_RATE_CTRL, 8'hff);
      look(rtccm_pkg::LOC_RATE_CTRL, 8'hff, 8'h7f);
      host.put(rtccm_pkg::LOC_RATE_CTRL, 8'h26);
      foreach (locs[k])
         host.put(locs[k], vals[k]);
      foreach (locs[k])
         look(locs[k], 8'hff, vals[k]);
      host.put(rtccm_pkg::LOC_TIME_SEC, 8'h59);
      host.put(rtccm_pkg::LOC_TIME_MIN, 8'h00);
      host.put(rtccm_pkg::LOC_TIME_HOUR, 8'h00);
      host.put(rtccm_pkg::LOC_ALARM_SEC, 8'h00);
      host.put(rtccm_pkg::LOC_ALARM_MIN, 8'h01);
      host.put(rtccm_pkg::LOC_ALARM_HOUR, 8'h00);
      host.get(rtccm_pkg::LOC_EVENT_FLAGS, rd);
      chk_bit(irq8, 1'b0);
      host.put(rtccm_pkg::LOC_MODE_CTRL, 8'h22);
      // first update ends 544 cycles after the run starts
      repeat (700) @(posedge mclk_i);
      #1;
      chk_bit(irq8, 1'b1);
      look(rtccm_pkg::LOC_TIME_SEC, 8'hff, 8'h00);
      look(rtccm_pkg::LOC_TIME_MIN, 8'hff, 8'h01);
      look(rtccm_pkg::LOC_TIME_HOUR, 8'hff, 8'h00);
      look(rtccm_pkg::LOC_EVENT_FLAGS, 8'hff, 8'hf0);
      chk_bit(irq8, 1'b0);
      look(rtccm_pkg::LOC_EVENT_FLAGS, 8'ha0, 8'h00);
      host.put(rtccm_pkg::LOC_MODE_CTRL, 8'h42);
      repeat (40) @(posedge mclk_i);
      #1;
      chk_bit(irq8, 1'b1);
      host.put(rtccm_pkg::LOC_MODE_CTRL, 8'h02);
      host.get(rtccm_pkg::LOC_EVENT_FLAGS, rd);
      chk_bit(irq8, 1'b0);
      count_sqw(100);
      chk_bit(1'(flips == 0), 1'b1);
      host.put(rtccm_pkg::LOC_MODE_CTRL, 8'h0a);
      count_sqw(100);
      chk_bit(1'(flips > 1), 1'b1);
      close_out();
   end
endmodule : test_rtc_cmos_register_map
`default_nettype wire
